// ===== include/cwr_defs.svh
`ifndef CWR_DEFS_SVH
`define CWR_DEFS_SVH
// Byte offsets of the register and its aliases
`define CWR_OFS_REG 4'h0
`define CWR_OFS_SET 4'h4
`define CWR_OFS_CLR 4'h8
`define CWR_OFS_INV 4'hc
// Field positions
`define CWR_WIN_MSB 13
`define CWR_WIN_LSB 8
`define CWR_RTY_MSB 3
`define CWR_RTY_LSB 0
// Reset values
`define CWR_WIN_RST 6'h37
`define CWR_RTY_RST 4'hf
// Preamble plus start-of-frame delimiter length in bytes
`define CWR_PRE_BYTES 6'h08
`endif

// ===== include/cwr_pkg.sv
package cwr_pkg;
  // Collision window and retry limit fields
  typedef struct packed {
    logic [5:0] collision_window_bytes;
    logic [3:0] retry_limit;
  } cwr_cfg_s;
  // Per-packet transmit states
  typedef enum logic [1:0] {
    CWR_IDLE = 2'b00,
    CWR_SEND = 2'b01,
    CWR_BACKOFF = 2'b10
  } cwr_state_e;
endpackage

// ===== src/cwr_top.sv
`timescale 1ns/1ns
`include "cwr_defs.svh"
module cwr_top (
  // Clock and reset
  input wire logic CLK_IN,
  input wire logic RST_IN,
  // AHB-Lite slave
  input wire logic HSEL_IN,
  input wire logic [31:0] HADDR_IN,
  input wire logic [1:0] HTRANS_IN,
  input wire logic HWRITE_IN,
  input wire logic [2:0] HSIZE_IN,
  input wire logic [31:0] HWDATA_IN,
  input wire logic HREADY_IN,
  output logic [31:0] HRDATA_OUT,
  output logic HREADYOUT_OUT,
  output logic HRESP_OUT,
  // Transmitter events from the MAC
  input wire logic TX_START_IN,
  input wire logic TX_BYTE_IN,
  input wire logic COLLISION_IN,
  input wire logic TX_DONE_IN,
  // Decisions to the MAC
  output logic RETRANSMIT_OUT,
  output logic ABORT_OUT,
  output logic LATE_COLLISION_OUT,
  output logic IN_WINDOW_OUT
);
  // Field register and bus pipeline
  cwr_pkg::cwr_cfg_s cfg_reg, cfg_next;
  logic wr_pend_reg, wr_pend_next;
  logic [3:0] wr_ofs_reg, wr_ofs_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [9:0] wval;
  logic [9:0] cur;
  logic take;
  // Transmit attempt tracking
  cwr_pkg::cwr_state_e state_reg, state_next;
  logic [5:0] byte_cnt_reg, byte_cnt_next;
  logic [3:0] retry_cnt_reg, retry_cnt_next;
  logic retry_limit_reg, retry_limit_next;
  logic abort_reg, abort_next;
  logic late_reg, late_next;

  // Only 16- and 32-bit transfers are taken; byte lanes are not decoded,
  // so a byte write would hit a whole field and is dropped instead
  assign take = HSEL_IN && HREADY_IN && HTRANS_IN[1] && (HSIZE_IN == 3'h1 || HSIZE_IN == 3'h2);
  // Only the implemented fields of the written word matter
  assign wval = {HWDATA_IN[`CWR_WIN_MSB:`CWR_WIN_LSB], HWDATA_IN[`CWR_RTY_MSB:`CWR_RTY_LSB]};
  // Current fields as one flat word for the alias arithmetic
  assign cur = cfg_reg;

  // Address phase: remember a write until its data stands in the data phase
  always_comb begin
    wr_pend_next = take && HWRITE_IN;
    wr_ofs_next = wr_ofs_reg;
    if (take) begin
      // Only the low nibble is decoded; the block repeats every 16 bytes
      wr_ofs_next = HADDR_IN[3:0];
    end
  end

  // Address phase registers
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      wr_pend_reg <= 1'b0;
      wr_ofs_reg <= 4'h0;
    end else begin
      wr_pend_reg <= wr_pend_next;
      wr_ofs_reg <= wr_ofs_next;
    end
  end

  // Data phase merge of the written word into the fields
  always_comb begin
    cfg_next = cfg_reg;
    if (wr_pend_reg) begin
      unique case (wr_ofs_reg)
        // Plain write replaces both fields
        `CWR_OFS_REG: cfg_next = wval;
        // Aliases touch only the bits written as one
        `CWR_OFS_SET: cfg_next = cur | wval;
        `CWR_OFS_CLR: cfg_next = cur & ~wval;
        `CWR_OFS_INV: cfg_next = cur ^ wval;
        // Offsets between the words are not registers
        default: cfg_next = cfg_reg;
      endcase
    end
  end

  // Field register; reset gives the default window and retry limit
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      cfg_reg <= {`CWR_WIN_RST, `CWR_RTY_RST};
    end else begin
      cfg_reg <= cfg_next;
    end
  end

  // Read data is built from the merged fields, so a read right after a
  // write sees the new value; the price is a path from write data to read data
  always_comb begin
    rdata_next = rdata_reg;
    if (take && !HWRITE_IN) begin
      // Unimplemented bits always read zero
      rdata_next = 32'h0000_0000;
      // Aliases read back the register itself
      if (HADDR_IN[3:2] == 2'h0 || HADDR_IN[1:0] == 2'h0) begin
        rdata_next[`CWR_WIN_MSB:`CWR_WIN_LSB] = cfg_next.collision_window_bytes;
        rdata_next[`CWR_RTY_MSB:`CWR_RTY_LSB] = cfg_next.retry_limit;
      end
    end
  end

  // Read data register; holds until the next read is taken
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      rdata_reg <= 32'h0000_0000;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // No wait states: every transfer finishes in its first data phase
  assign HRDATA_OUT = rdata_reg;
  assign HREADYOUT_OUT = 1'b1;
  // Refused accesses are ignored quietly, so the response stays OKAY
  assign HRESP_OUT = 1'b0;

  // Transmit attempt tracking; a collision after the window is late and not retried.
  // The byte count stops at the window value, so it never wraps on long frames;
  // the retry count lives across attempts of one packet only
  always_comb begin
    state_next = state_reg;
    byte_cnt_next = byte_cnt_reg;
    retry_cnt_next = retry_cnt_reg;
    retry_limit_next = 1'b0;
    abort_next = 1'b0;
    late_next = 1'b0;
    unique case (state_reg)
      cwr_pkg::CWR_IDLE: begin
        // New packet: fresh byte and retry counts
        if (TX_START_IN) begin
          state_next = cwr_pkg::CWR_SEND;
          byte_cnt_next = 6'h00;
          retry_cnt_next = 4'h0;
        end
      end
      cwr_pkg::CWR_SEND: begin
        // Preamble and delimiter bytes are counted like any other
        if (TX_BYTE_IN && byte_cnt_reg != cfg_reg.collision_window_bytes) begin
          byte_cnt_next = byte_cnt_reg + 6'h01;
        end
        if (COLLISION_IN) begin
          // Window already closed: late collision, never retried
          if (byte_cnt_reg == cfg_reg.collision_window_bytes) begin
            late_next = 1'b1;
            state_next = cwr_pkg::CWR_IDLE;
          end else if (retry_cnt_reg >= cfg_reg.retry_limit) begin
            // Retry budget spent: excessive collisions
            abort_next = 1'b1;
            state_next = cwr_pkg::CWR_IDLE;
          end else begin
            // Retry and wait for the MAC to restart the packet
            retry_limit_next = 1'b1;
            retry_cnt_next = retry_cnt_reg + 4'h1;
            state_next = cwr_pkg::CWR_BACKOFF;
          end
        end else if (TX_DONE_IN) begin
          // Clean finish; the retry count is dropped with the packet
          state_next = cwr_pkg::CWR_IDLE;
        end
      end
      cwr_pkg::CWR_BACKOFF: begin
        // MAC restarts the same packet; retries keep counting
        if (TX_START_IN) begin
          state_next = cwr_pkg::CWR_SEND;
          byte_cnt_next = 6'h00;
        end
      end
      default: state_next = cwr_pkg::CWR_IDLE;
    endcase
  end

  // Transmit registers
  // Decision pulses default low in the next-state logic, so each lasts one cycle
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      state_reg <= cwr_pkg::CWR_IDLE;
      byte_cnt_reg <= 6'h00;
      retry_cnt_reg <= 4'h0;
      retry_limit_reg <= 1'b0;
      abort_reg <= 1'b0;
      late_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      byte_cnt_reg <= byte_cnt_next;
      retry_cnt_reg <= retry_cnt_next;
      retry_limit_reg <= retry_limit_next;
      abort_reg <= abort_next;
      late_reg <= late_next;
    end
  end

  // Decision pulses straight from flip-flops
  assign RETRANSMIT_OUT = retry_limit_reg;
  assign ABORT_OUT = abort_reg;
  // Late collisions are only flagged; the MAC decides how to report them
  assign LATE_COLLISION_OUT = late_reg;
  // Window is open while counting and the programmed byte count is not yet reached
  assign IN_WINDOW_OUT = (state_reg == cwr_pkg::CWR_SEND) &&
    (byte_cnt_reg != cfg_reg.collision_window_bytes);
endmodule // cwr_top

// ===== testbench/cwr_properties.sv
`timescale 1ns/1ns
module cwr_properties (
  // Clock and reset
  input wire logic CLK_IN,
  input wire logic RST_IN,
  // Bus and transmit signals
  input wire logic [31:0] HRDATA_OUT,
  input wire logic HREADYOUT_OUT,
  input wire logic HRESP_OUT,
  input wire logic COLLISION_IN,
  input wire logic IN_WINDOW_OUT,
  input wire logic RETRANSMIT_OUT,
  input wire logic ABORT_OUT,
  input wire logic LATE_COLLISION_OUT
);
  // One domain, quiet in reset
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (RST_IN);
  chk_bus_okay: assert property (HREADYOUT_OUT && !HRESP_OUT) else $error("stall");
  chk_unused_zero: assert property (~|{HRDATA_OUT[31:14], HRDATA_OUT[7:4]}) else $error("unused set");
  chk_retry_cause: assert property (RETRANSMIT_OUT |-> $past(COLLISION_IN) && $past(IN_WINDOW_OUT)) else $error("retry");
  chk_abort_cause: assert property (ABORT_OUT |-> $past(COLLISION_IN) && $past(IN_WINDOW_OUT)) else $error("abort");
  chk_late_cause: assert property (LATE_COLLISION_OUT |-> $past(COLLISION_IN) && !$past(IN_WINDOW_OUT)) else $error("late");
  chk_coll_answer: assert property (COLLISION_IN && IN_WINDOW_OUT |=> RETRANSMIT_OUT ^ ABORT_OUT) else $error("none");
  chk_one_decision: assert property ($onehot0({RETRANSMIT_OUT, ABORT_OUT, LATE_COLLISION_OUT})) else $error("two");
  chk_retry_pulse: assert property (RETRANSMIT_OUT |=> !RETRANSMIT_OUT) else $error("held");
endmodule // cwr_properties

// ===== testbench/cwr_phy_model.sv
`timescale 1ns/1ns
module cwr_phy_model (
  // Clock
  input wire logic clk_in,
  // Medium events
  output logic start_out,
  output logic byte_out,
  output logic coll_out,
  output logic done_out
);
  // Lines idle low between frames
  initial {start_out, byte_out, coll_out, done_out} = 4'h0;
  // Preamble bytes are pulsed like any other
  task automatic frame(input int n, input logic c);
    @(posedge clk_in) start_out <= 1'b1;
    @(posedge clk_in) start_out <= 1'b0;
    repeat (n) begin
      @(posedge clk_in) byte_out <= 1'b1;
      @(posedge clk_in) byte_out <= 1'b0;
    end
    @(posedge clk_in) {coll_out, done_out} <= {c, !c};
    @(posedge clk_in) {coll_out, done_out} <= 2'h0;
    repeat (3) @(posedge clk_in);
  endtask
endmodule // cwr_phy_model

// ===== testbench/test_mac_collision_retry_config.sv
`timescale 1ns/1ns
module test_mac_collision_retry_config;
  logic clk = 1'b0, rst = 1'b1, hsel = 1'b0, hw = 1'b0, rdy, rsp, rt, ab, lt, iw, st, by, co, dn;
  logic [1:0] ht = 2'h0;
  logic [2:0] hz = 3'h2;
  logic [31:0] ha = 32'h0, hd = 32'h0, rdat, r;
  int err_total = 0, check_count = 0, n_rt = 0, n_ab = 0, n_lt = 0, cyc = 0;
  cwr_top cwr_top_i (.CLK_IN(clk), .RST_IN(rst), .HSEL_IN(hsel), .HADDR_IN(ha), .HTRANS_IN(ht),
    .HWRITE_IN(hw), .HSIZE_IN(hz), .HWDATA_IN(hd), .HREADY_IN(rdy), .HRDATA_OUT(rdat),
    .HREADYOUT_OUT(rdy), .HRESP_OUT(rsp), .TX_START_IN(st), .TX_BYTE_IN(by), .COLLISION_IN(co),
    .TX_DONE_IN(dn), .RETRANSMIT_OUT(rt), .ABORT_OUT(ab), .LATE_COLLISION_OUT(lt), .IN_WINDOW_OUT(iw));
  cwr_phy_model cwr_phy_model_i (.clk_in(clk), .start_out(st), .byte_out(by), .coll_out(co), .done_out(dn));
  initial forever #20 clk = ~clk;
  // Tally decisions; a hang ends the run
  always @(posedge clk) begin
    n_rt += (rt === 1'b1);
    n_ab += (ab === 1'b1);
    n_lt += (lt === 1'b1);
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      stop_test();
    end
  end
  task xfer(input logic [31:0] a, input logic w, input logic [2:0] s, input logic [31:0] d);
    @(posedge clk) {hsel, ht, ha, hw, hz} <= {1'b1, 2'h2, a, w, s};
    do @(posedge clk); while (rdy !== 1'b1);
    {hsel, ht, hd} <= {1'b0, 2'h0, d};
    do @(posedge clk); while (rdy !== 1'b1);
    r = rdat;
  endtask
  task chk(input logic [31:0] g, e);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  task rd(input logic [31:0] a, e);
    xfer(a, 1'b0, 3'h2, 32'h0);
    chk(r, e);
  endtask
  task stop_test;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Register access, then transmit decisions
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd(32'h0, 32'h370f);
    xfer(32'h0, 1'b1, 3'h2, 32'hffffffff);
    rd(32'h0, 32'h3f0f);
    xfer(32'h0, 1'b1, 3'h0, 32'h0);
    rd(32'h0, 32'h3f0f);
    xfer(32'h0, 1'b1, 3'h1, 32'h0105);
    rd(32'h0, 32'h0105);
    xfer(32'h4, 1'b1, 3'h2, 32'h2000);
    rd(32'h0, 32'h2105);
    xfer(32'h8, 1'b1, 3'h2, 32'h0101);
    rd(32'h0, 32'h2004);
    xfer(32'hc, 1'b1, 3'h2, 32'h0003);
    rd(32'hc, 32'h2007);
    $display("register test done");
    // Window of ten bytes, two retries
    xfer(32'h0, 1'b1, 3'h2, 32'h0a02);
    cwr_phy_model_i.frame(9, 1'b1);
    cwr_phy_model_i.frame(3, 1'b1);
    cwr_phy_model_i.frame(3, 1'b1);
    cwr_phy_model_i.frame(10, 1'b1);
    cwr_phy_model_i.frame(5, 1'b0);
    chk(n_rt, 2);
    chk(n_ab, 1);
    chk(n_lt, 1);
    $display("transmit test done");
    stop_test();
  end
endmodule // test_mac_collision_retry_config
bind cwr_top cwr_properties cwr_properties_i (.CLK_IN(CLK_IN), .RST_IN(RST_IN), .HRDATA_OUT(HRDATA_OUT),
  .HREADYOUT_OUT(HREADYOUT_OUT), .HRESP_OUT(HRESP_OUT), .COLLISION_IN(COLLISION_IN), .IN_WINDOW_OUT(IN_WINDOW_OUT),
  .RETRANSMIT_OUT(RETRANSMIT_OUT), .ABORT_OUT(ABORT_OUT), .LATE_COLLISION_OUT(LATE_COLLISION_OUT));
